// *** ctm_top.sv ***
/*
 Compact 10-bit timer with compare, timer/counter and PWM modes,
 AHB-Lite register slave and one output pin.
 Assumes a single 100 MHz hclk, synchronous pin clock input, one master.
*/
// What this block does
// - Mode 00 selects compare match output
// - Clear-select low: clear on P, flag both
// - Clear-select high: clear on A match
// - Clear-select high: never raise P flag
// - Clear-select high, A zero: wrap at 3FF, no flag
// - Compare mode: A match and on-bit rise move pin
// - Output field: none, low, high, toggle
// - On-bit rise loads initial pin level
// - Mode 11 like compare, pin undriven
// - Mode 10 makes edge-aligned PWM
// - PWM ignores clear-select; swap picks period
// - PWM flags each A and P match
// - PWM field enables or forces; polarity inverts
// - Swap zero: P sets 128-step period
// - Duty at or above period: always active
// - Swap set: A period, P duty
// - Counting continues while pin is forced
// - P matches top bits of next count, low seven zero
// - On rise clears counter; fall freezes
// - PWM codes: inactive, active, waveform
`timescale 1ns/1ns
module ctm_top
#(
	parameter int WIDTH = 10
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic pin_clk,
	output logic timer_out,
	output logic timer_out_en
);
	import ctm_pkg::*;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic timer_on_bit;
	logic [2:0] clk_sel;
	logic [2:0] compare_p_value;
	ctm_ctrl_t ctrl;
	logic [WIDTH-1:0] compare_a_value;
	logic match_a_flag;
	logic match_p_flag;
	ctm_bus_t bus_state;
	logic [11:0] bus_addr;
	logic on_q;
	logic pin_q;
	logic [1:0] pre;
	logic out_q;

	logic start;
	logic tick;
	logic [WIDTH-1:0] count;
	ctm_events_t ev;
	logic is_pwm;
	logic clr_on_a;
	logic ev_a;
	logic ev_p;
	logic [WIDTH:0] period;
	logic [WIDTH:0] duty;
	logic pwm_act;
	logic pwm_lvl;
	logic wr_en;
	logic rd_en;
	logic take;
	logic next_out;

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	assign take = hsel && hready && htrans[1];
	assign wr_en = bus_state == CTM_BUS_WR;
	assign rd_en = bus_state == CTM_BUS_RD;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bus_state <= CTM_BUS_IDLE;
			bus_addr <= '0;
		end
		else if (ce)
		begin
			if (take)
			begin
				bus_state <= hwrite ? CTM_BUS_WR : CTM_BUS_RD;
				bus_addr <= haddr[11:0];
			end
			else if (hready)
				bus_state <= CTM_BUS_IDLE;
		end
	end

	always_comb
	begin
		hrdata = 32'h0000_0000;
		if (!rd_en)
			hrdata = 32'h0000_0000;
		else if (bus_addr == CTM_OFS_CTRL0)
			hrdata[7:0] = {1'b0, clk_sel, timer_on_bit, compare_p_value};
		else if (bus_addr == CTM_OFS_CTRL1)
			hrdata[7:0] = ctrl;
		else if (bus_addr == CTM_OFS_COUNT)
			hrdata[WIDTH-1:0] = count;
		else if (bus_addr == CTM_OFS_CMPA)
			hrdata[WIDTH-1:0] = compare_a_value;
		else if (bus_addr == CTM_OFS_FLAGS)
			hrdata[1:0] = {match_p_flag, match_a_flag};
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			timer_on_bit <= CTM_RST_CTRL[CTM_C0_ON];
			clk_sel <= CTM_RST_CTRL[2:0];
			compare_p_value <= CTM_RST_CTRL[2:0];
			ctrl <= CTM_RST_CTRL;
			compare_a_value <= CTM_RST_CMPA;
		end
		else if (ce && wr_en)
		begin
			if (bus_addr == CTM_OFS_CTRL0)
			begin
				clk_sel <= hwdata[CTM_C0_CK_LO +: 3];
				timer_on_bit <= hwdata[CTM_C0_ON];
				compare_p_value <= hwdata[2:0];
			end
			else if (bus_addr == CTM_OFS_CTRL1)
				ctrl <= hwdata[7:0];
			else if (bus_addr == CTM_OFS_CMPA)
				compare_a_value <= hwdata[WIDTH-1:0];
		end
	end

	// ------------------------------------------------------------
	// Clock source and on-bit edge
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			on_q <= 1'b0;
			pin_q <= 1'b0;
			pre <= '0;
		end
		else if (ce)
		begin
			on_q <= timer_on_bit;
			pin_q <= pin_clk;
			pre <= pre + 1'b1;
		end
	end

	assign start = timer_on_bit && !on_q;

	always_comb
	begin
		case (clk_sel)
			3'h0: tick = pre == CTM_PRE_DIV4;
			3'h1: tick = 1'b1;
			3'h6: tick = pin_clk && !pin_q;
			3'h7: tick = !pin_clk && pin_q;
			default: tick = 1'b0;
		endcase
		tick = tick && timer_on_bit && !start;
	end

	// ------------------------------------------------------------
	// Counter core
	// ------------------------------------------------------------
	assign is_pwm = ctrl.mode == CTM_MODE_PWM;
	assign clr_on_a = is_pwm ? ctrl.dpx : ctrl.clr_sel;

	ctm_counter #(.WIDTH(WIDTH)) u_counter
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.tick(tick),
		.start(start),
		.clr_on_a(clr_on_a),
		.cmp_a(compare_a_value),
		.cmp_p(compare_p_value),
		.count(count),
		.events(ev)
	);

	// Flags outside PWM: A suppressed at zero when clearing on A; P never when on A
	always_comb
	begin
		ev_a = ev.match_a;
		ev_p = ev.match_p;
		if (!is_pwm && clr_on_a)
		begin
			if (compare_a_value == '0)
				ev_a = 1'b0;
			ev_p = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			match_a_flag <= 1'b0;
			match_p_flag <= 1'b0;
		end
		else if (ce)
		begin
			if (ev_a)
				match_a_flag <= 1'b1;
			else if (wr_en && bus_addr == CTM_OFS_FLAGS &&
				hwdata[CTM_FL_A])
				match_a_flag <= 1'b0;
			if (ev_p)
				match_p_flag <= 1'b1;
			else if (wr_en && bus_addr == CTM_OFS_FLAGS &&
				hwdata[CTM_FL_P])
				match_p_flag <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// PWM waveform
	// ------------------------------------------------------------
	always_comb
	begin
		if (ctrl.dpx)
		begin
			period = {1'b0, compare_a_value};
			duty = (compare_p_value == CTM_P_ZERO) ? 11'h400 :
				{1'b0, compare_p_value, 7'h00};
		end
		else
		begin
			period = (compare_p_value == CTM_P_ZERO) ? 11'h400 :
				{1'b0, compare_p_value, 7'h00};
			duty = {1'b0, compare_a_value};
		end
	end

	// Active from clear until duty, always when duty covers period
	assign pwm_act = (duty >= period) || ({1'b0, count} < duty);

	always_comb
	begin
		case (ctrl.io)
			CTM_PWM_INACT: pwm_lvl = 1'b0;
			CTM_PWM_ACT: pwm_lvl = 1'b1;
			CTM_PWM_WAVE: pwm_lvl = pwm_act;
			default: pwm_lvl = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Output pin
	// ------------------------------------------------------------
	always_comb
	begin
		next_out = out_q;
		if (is_pwm)
			next_out = ctrl.oc ? pwm_lvl : !pwm_lvl;
		else if (start)
			next_out = ctrl.oc;
		else if (ev_a && ctrl.mode == CTM_MODE_CMP)
		begin
			case (ctrl.io)
				CTM_IO_LOW: next_out = 1'b0;
				CTM_IO_HIGH: next_out = 1'b1;
				CTM_IO_TOG: next_out = !out_q;
				default: next_out = out_q;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			out_q <= 1'b0;
		else if (ce)
			out_q <= next_out;
	end

	assign timer_out = out_q ^ ctrl.pol;
	assign timer_out_en = ctrl.mode == CTM_MODE_CMP || is_pwm;

endmodule

// *** ctm_pkg.sv ***
/*
 Package for the compact 10-bit timer: register map, field positions,
 reset values, mode, output-function and bus state encodings, control and event carrier types.
 Assumes a 32-bit AHB-Lite bus with word-aligned registers.
*/
package ctm_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [11:0] CTM_OFS_CTRL0 = 12'h000;
	localparam logic [11:0] CTM_OFS_CTRL1 = 12'h004;
	localparam logic [11:0] CTM_OFS_COUNT = 12'h008;
	localparam logic [11:0] CTM_OFS_CMPA = 12'h00C;
	localparam logic [11:0] CTM_OFS_FLAGS = 12'h010;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTM_C0_ON = 3;
	localparam int CTM_C0_CK_LO = 4;
	localparam int CTM_C1_CLR = 0;
	localparam int CTM_C1_DPX = 1;
	localparam int CTM_C1_POL = 2;
	localparam int CTM_C1_OC = 3;
	localparam int CTM_C1_IO_LO = 4;
	localparam int CTM_C1_MODE_LO = 6;
	localparam int CTM_FL_A = 0;
	localparam int CTM_FL_P = 1;

	// ------------------------------------------------------------
	// Reset values and counter constants
	// ------------------------------------------------------------
	localparam logic [7:0] CTM_RST_CTRL = 8'h00;
	localparam logic [9:0] CTM_RST_CMPA = 10'h000;
	localparam logic [9:0] CTM_CNT_MAX = 10'h3FF;
	localparam logic [2:0] CTM_P_ZERO = 3'h0;
	localparam logic [1:0] CTM_PRE_DIV4 = 2'h3;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		CTM_MODE_CMP = 2'h0,
		CTM_MODE_UNDEF = 2'h1,
		CTM_MODE_PWM = 2'h2,
		CTM_MODE_TMR = 2'h3
	} ctm_mode_t;

	typedef enum logic [1:0] {
		CTM_IO_NONE = 2'h0,
		CTM_IO_LOW = 2'h1,
		CTM_IO_HIGH = 2'h2,
		CTM_IO_TOG = 2'h3
	} ctm_io_t;

	typedef enum logic [1:0] {
		CTM_PWM_INACT = 2'h0,
		CTM_PWM_ACT = 2'h1,
		CTM_PWM_WAVE = 2'h2,
		CTM_PWM_UNDEF = 2'h3
	} ctm_pwm_io_t;

	// Bus data phase state, Gray except between IDLE and RD
	typedef enum logic [1:0] {
		CTM_BUS_IDLE = 2'h0,
		CTM_BUS_WR = 2'h1,
		CTM_BUS_RD = 2'h3
	} ctm_bus_t;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] io;
		logic oc;
		logic pol;
		logic dpx;
		logic clr_sel;
	} ctm_ctrl_t;

	typedef struct packed {
		logic match_a;
		logic match_p;
		logic wrap;
	} ctm_events_t;

endpackage

// *** ctm_counter.sv ***
/*
 10-bit count-up core with both comparators and clear selection.
 Assumes tick is one-cycle qualified by the caller and start is the
 on-bit rising edge.
*/
`timescale 1ns/1ns
module ctm_counter
#(
	parameter int WIDTH = 10
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic tick,
	input wire logic start,
	input wire logic clr_on_a,
	input wire logic [WIDTH-1:0] cmp_a,
	input wire logic [2:0] cmp_p,
	output logic [WIDTH-1:0] count,
	output ctm_pkg::ctm_events_t events
);
	import ctm_pkg::*;

	logic hit_a;
	logic hit_p;
	logic at_max;
	logic do_clear;
	logic [WIDTH:0] next_count;

	// ------------------------------------------------------------
	// Comparators
	// ------------------------------------------------------------
	// P matches as the count reaches a multiple of 128; code 000 is overflow
	assign next_count = {1'b0, count} + {{WIDTH{1'b0}}, 1'b1};
	assign hit_a = tick && (count == cmp_a);
	assign hit_p = tick && (next_count[WIDTH-1 -: 3] == cmp_p) &&
		(next_count[WIDTH-4:0] == '0);
	assign at_max = tick && (count == CTM_CNT_MAX);
	// A zero compare-A value never clears; the count wraps at its maximum
	assign do_clear = clr_on_a ? ((hit_a && cmp_a != '0) || at_max) :
		hit_p;

	assign events.match_a = hit_a;
	assign events.match_p = hit_p;
	assign events.wrap = at_max;

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			count <= '0;
		else if (ce)
		begin
			if (start)
				count <= '0;
			else if (do_clear)
				count <= '0;
			else if (tick)
				count <= count + 1'b1;
		end
	end

endmodule

// *** ctm_chk_sva.sv ***
/*
 Checker for the compact timer: bus answers and pin relations.
 Assumes it is bound to ctm_top and sees only its ports.
*/
`timescale 1ns/1ns
module ctm_chk
import ctm_pkg::*;
#(
	parameter int WIDTH = 10
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic timer_out,
	input wire logic timer_out_en
);
// ----
// Shadow of bus phases and mode
// ----
logic rq, wq;
logic [1:0] wh, md, io;
logic [11:0] aq;
always_ff @(posedge hclk or negedge hresetn)
	if (!hresetn)
	begin
		rq <= 1'b0;
		wq <= 1'b0;
		wh <= 2'h0;
		aq <= 12'h000;
		md <= 2'h0;
		io <= 2'h0;
	end
	else if (ce)
	begin
		rq <= hsel && hready && htrans[1] && !hwrite;
		wq <= hsel && hready && htrans[1] && hwrite;
		wh <= {wh[0], wq};
		aq <= haddr[11:0];
		if (wq && aq == CTM_OFS_CTRL1)
		begin
			md <= hwdata[7:6];
			io <= hwdata[5:4];
		end
	end
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);
property p_bus; hreadyout && !hresp; endproperty
a_bus: assert property (p_bus) else $error("bus answer not okay");
property p_idle; !rq |-> hrdata == 32'h0; endproperty
a_idle: assert property (p_idle) else $error("read data outside phase");
property p_unmap; rq && aq > CTM_OFS_FLAGS |-> hrdata == 32'h0; endproperty
a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
property p_cnt; rq && aq == CTM_OFS_COUNT |-> hrdata[31:10] == 22'h0; endproperty
a_cnt: assert property (p_cnt) else $error("count wider than 10");
property p_flg; rq && aq == CTM_OFS_FLAGS |-> hrdata[31:2] == 30'h0; endproperty
a_flg: assert property (p_flg) else $error("extra flag bits");
property p_en; timer_out_en == (md == CTM_MODE_CMP || md == CTM_MODE_PWM);
endproperty
a_en: assert property (p_en) else $error("pin enable wrong");
property p_tmr; md == CTM_MODE_TMR && !wq |=> !timer_out_en; endproperty
a_tmr: assert property (p_tmr) else $error("pin driven in timer mode");
property p_hold; md == CTM_MODE_CMP && io == CTM_IO_NONE && !wq && wh == 2'h0
	|=> $stable(timer_out); endproperty
a_hold: assert property (p_hold) else $error("pin moved with no action");
property p_frc; md == CTM_MODE_PWM && io == CTM_PWM_INACT && !wq && wh == 2'h0
	|=> $stable(timer_out); endproperty
a_frc: assert property (p_frc) else $error("forced pin moved");
endmodule
bind ctm_top ctm_chk #(.WIDTH(WIDTH)) u_chk (.hclk(hclk), .hresetn(hresetn),
	.ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .timer_out(timer_out), .timer_out_en(timer_out_en));

// *** tb.sv ***
/*
 Testbench for ctm_top: bus tasks, pin clock pulses, read monitor.
 Assumes the ctm_pkg register map and pin clock select 6.
*/
`timescale 1ns/1ns
module tb;
import ctm_pkg::*;
// ----
// Signals and tasks
// ----
typedef struct {logic [31:0] e; logic pc; logic pv;} ctm_exp_t;
ctm_exp_t q[$];
ctm_exp_t x;
logic hclk = 1'b0;
logic hresetn = 1'b0;
logic hsel = 1'b0;
logic hwrite = 1'b0;
logic pin_clk = 1'b0;
logic ph = 1'b0;
logic [1:0] htrans = 2'h0;
logic [31:0] haddr = 32'h0;
logic [31:0] hwdata = 32'h0;
logic [31:0] hrdata, r;
logic hreadyout, hresp, timer_out, timer_out_en;
int failures = 0;
int checked = 0;
always #5 hclk = ~hclk;
ctm_top u_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
	.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .pin_clk(pin_clk),
	.timer_out(timer_out), .timer_out_en(timer_out_en));
task chk(input string n, input logic [31:0] s, input logic [31:0] e);
	checked++;
	if (s !== e)
	begin
		failures++;
		$display("[ERR] %s expected %h seen %h", n, e, s);
	end
endtask
task give_verdict;
	if (failures == 0 && checked > 0)
		$display("RESULT: PASS");
	else
		$display("RESULT: FAIL");
	$finish;
endtask
task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
	hsel <= 1'b1;
	haddr <= {20'h0, a};
	hwrite <= w;
	htrans <= 2'h2;
	do @(posedge hclk); while (hreadyout !== 1'b1);
	htrans <= 2'h0;
	hwdata <= d;
	ph <= !w;
	do @(posedge hclk); while (hreadyout !== 1'b1);
	ph <= 1'b0;
endtask
task rd(input logic [11:0] a, input logic [31:0] e, input logic pc,
	input logic pv);
	q.push_back('{e, pc, pv});
	bus(1'b0, a, 32'h0);
endtask
task pls(input int n);
	// Idle edge first, so no pin edge meets the on-bit rising cycle
	@(posedge hclk);
	repeat (n)
	begin
		pin_clk <= 1'b1;
		repeat (2) @(posedge hclk);
		pin_clk <= 1'b0;
		repeat (2) @(posedge hclk);
	end
	repeat (3) @(posedge hclk);
endtask
always @(posedge hclk)
	if (ph)
	begin
		x = q.pop_front();
		chk("hrdata", hrdata, x.e);
		if (x.pc)
			chk("timer_out", {31'h0, timer_out}, {31'h0, x.pv});
	end
initial
begin
	repeat (30000) @(posedge hclk);
	failures++;
	give_verdict;
end
// ----
// Scenarios
// ----
initial
begin
	void'($urandom(43071));
	repeat (10) @(posedge hclk);
	hresetn <= 1'b1;
	@(posedge hclk);
	for (int i = 0; i < 6; i++) rd(12'(i * 4), 32'h0, 1'b1, 1'b0);
	r = $urandom;
	bus(1'b1, CTM_OFS_CMPA, r);
	rd(CTM_OFS_CMPA, {22'h0, r[9:0]}, 1'b1, 1'b0);
	bus(1'b1, CTM_OFS_CTRL1, 32'h20);
	bus(1'b1, CTM_OFS_CMPA, 32'h5);
	bus(1'b1, CTM_OFS_CTRL0, 32'h69);
	pls(5);
	rd(CTM_OFS_COUNT, 32'h5, 1'b1, 1'b0);
	rd(CTM_OFS_FLAGS, 32'h0, 1'b1, 1'b0);
	pls(1);
	rd(CTM_OFS_FLAGS, 32'h1, 1'b1, 1'b1);
	bus(1'b1, CTM_OFS_FLAGS, 32'h1);
	pls(121);
	rd(CTM_OFS_COUNT, 32'h7F, 1'b1, 1'b1);
	pls(1);
	rd(CTM_OFS_COUNT, 32'h0, 1'b1, 1'b1);
	rd(CTM_OFS_FLAGS, 32'h2, 1'b1, 1'b1);
	pls(3);
	bus(1'b1, CTM_OFS_CTRL0, 32'h61);
	pls(4);
	rd(CTM_OFS_COUNT, 32'h3, 1'b1, 1'b1);
	bus(1'b1, CTM_OFS_CTRL0, 32'h69);
	rd(CTM_OFS_COUNT, 32'h0, 1'b1, 1'b0);
	bus(1'b1, CTM_OFS_CTRL0, 32'h61);
	bus(1'b1, CTM_OFS_CTRL1, 32'h39);
	bus(1'b1, CTM_OFS_CMPA, 32'hC8);
	bus(1'b1, CTM_OFS_FLAGS, 32'h3);
	bus(1'b1, CTM_OFS_CTRL0, 32'h69);
	pls(129);
	rd(CTM_OFS_COUNT, 32'h81, 1'b1, 1'b1);
	rd(CTM_OFS_FLAGS, 32'h0, 1'b1, 1'b1);
	pls(72);
	rd(CTM_OFS_COUNT, 32'h0, 1'b1, 1'b0);
	rd(CTM_OFS_FLAGS, 32'h1, 1'b1, 1'b0);
	bus(1'b1, CTM_OFS_CTRL0, 32'h61);
	bus(1'b1, CTM_OFS_CMPA, 32'h0);
	bus(1'b1, CTM_OFS_FLAGS, 32'h3);
	bus(1'b1, CTM_OFS_CTRL0, 32'h69);
	pls(1023);
	rd(CTM_OFS_COUNT, 32'h3FF, 1'b1, 1'b1);
	pls(1);
	rd(CTM_OFS_COUNT, 32'h0, 1'b1, 1'b1);
	rd(CTM_OFS_FLAGS, 32'h0, 1'b1, 1'b1);
	bus(1'b1, CTM_OFS_CTRL0, 32'h61);
	bus(1'b1, CTM_OFS_CTRL1, 32'hC1);
	rd(CTM_OFS_CTRL1, 32'hC1, 1'b0, 1'b0);
	bus(1'b1, CTM_OFS_CTRL1, 32'hA8);
	bus(1'b1, CTM_OFS_CMPA, 32'h3);
	bus(1'b1, CTM_OFS_CTRL0, 32'h69);
	pls(2);
	rd(CTM_OFS_COUNT, 32'h2, 1'b1, 1'b1);
	pls(2);
	rd(CTM_OFS_COUNT, 32'h4, 1'b1, 1'b0);
	bus(1'b1, CTM_OFS_CTRL0, 32'h61);
	bus(1'b1, CTM_OFS_CTRL1, 32'h89);
	bus(1'b1, CTM_OFS_FLAGS, 32'h3);
	bus(1'b1, CTM_OFS_CTRL0, 32'h69);
	pls(130);
	rd(CTM_OFS_COUNT, 32'h2, 1'b1, 1'b0);
	rd(CTM_OFS_FLAGS, 32'h3, 1'b1, 1'b0);
	bus(1'b1, CTM_OFS_CTRL0, 32'h61);
	bus(1'b1, CTM_OFS_CTRL1, 32'h94);
	bus(1'b1, CTM_OFS_CTRL0, 32'h69);
	rd(CTM_OFS_CTRL1, 32'h94, 1'b1, 1'b1);
	bus(1'b1, CTM_OFS_CTRL0, 32'h61);
	bus(1'b1, CTM_OFS_CTRL1, 32'hAA);
	bus(1'b1, CTM_OFS_CMPA, 32'h5);
	bus(1'b1, CTM_OFS_CTRL0, 32'h69);
	pls(3);
	rd(CTM_OFS_COUNT, 32'h3, 1'b1, 1'b1);
	pls(4);
	rd(CTM_OFS_COUNT, 32'h1, 1'b1, 1'b1);
	give_verdict;
end
endmodule
